// file: core/shp_dev.sv
`timescale 1ns/100ps
// Operation
// [RULE1] host_select low: host port, high: test port
// [RULE2] serial_data_out copies serial_data_in combinationally
// [RULE3] host starts, ends access, command first
// [RULE4] 16-bit command: rw, two reserved, increment, address
// [RULE5] command bits captured on serial clock rising edges
// [RULE6] no increment: exactly one data word
// [RULE7] increment: consecutive words go to consecutive addresses
// [RULE8] single video register read returns zero lsb
// [RULE9] host should read two or more with increment
// [RULE10] data words msb first, rising edge sampled
// [RULE11] read: rw high, four pclk wait
// [RULE12] read data shifted out on falling edges
// [RULE13] one chip select asserted during chained read
// [RULE14] write: rw low, one pclk wait
// [RULE15] increment write: same wait between data words
// [RULE16] write words pass unchanged to serial_data_out
// [RULE17] every selected chained device takes broadcast write
// [RULE18] before valid video keep serial clock under 10MHz
// [RULE19] unlocked: 445ns write gap, 1187ns read gap
// [RULE20] chip select high clears counters, ignores clock
module shp_dev
  import shp_pkg::*;
(
  input  wire logic                      i_clk,
  input  wire logic                      i_rst_b,
  shp_link_if.dev                        link,
  output logic [shp_pkg::ADDR_W-1:0]     o_reg_addr,
  output logic [shp_pkg::DATA_W-1:0]     o_reg_wdata,
  output logic                           o_reg_we,
  output logic                           o_reg_re,
  input  wire logic [shp_pkg::DATA_W-1:0] i_reg_rdata,
  input  wire logic                      i_reg_video,
  output logic                           o_jtag_tck,
  output logic                           o_jtag_tms,
  output logic                           o_jtag_tdi,
  input  wire logic                      i_jtag_tdo
);
  import shp_pkg::*;

  typedef enum logic [3:0] {
    ST_CMD  = 4'b0001,
    ST_WR   = 4'b0010,
    ST_RD   = 4'b0100,
    ST_DONE = 4'b1000
  } shp_dev_state_e;

  shp_dev_state_e        state;
  logic                  sclk_m;
  logic                  sclk_s;
  logic                  sclk_d;
  logic                  cs_m;
  logic                  cs_s;
  logic                  serial_data_in_m;
  logic                  serial_data_in_s;
  logic                  host_mode;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  word_done;
  logic [BITCNT_W-1:0]   bitcnt;
  logic [CMD_W-1:0]      shin;
  logic [CMD_W-1:0]      word;
  logic                  ainc;
  logic                  rd_frame;
  logic                  fetch_req;
  logic                  load_rd;
  logic [DATA_W-1:0]     rd_sh;

  assign host_mode = ~link.host_select;  // [RULE1]

  // test port sees the shared pins only in test mode
  assign o_jtag_tck = link.host_select ? link.sclk : 1'b0;  // [RULE1]
  assign o_jtag_tms = link.host_select ? link.cs_n : 1'b1;  // [RULE1]
  assign o_jtag_tdi = link.host_select ? link.serial_data_in : 1'b0;  // [RULE1]

  // unclocked loop-through; test mode and a selected read replace it
  always_comb begin
    if (!host_mode) begin
      link.serial_data_out = i_jtag_tdo;  // [RULE1]
    end else if ((state == ST_RD || (state == ST_DONE && rd_frame)) && !link.cs_n) begin
      // without increment the last read bit stands until chip select rises
      link.serial_data_out = rd_sh[DATA_W-1];  // [RULE12]
    end else begin
      link.serial_data_out = link.serial_data_in;  // [RULE2] [RULE16]
    end
  end

  // two-flop synchronisers for the link pins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      cs_m   <= 1'b1;
      cs_s   <= 1'b1;
      serial_data_in_m <= 1'b0;
      serial_data_in_s <= 1'b0;
    end else begin
      sclk_m <= link.sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      cs_m   <= link.cs_n;
      cs_s   <= cs_m;
      serial_data_in_m <= link.serial_data_in;
      serial_data_in_s <= serial_data_in_m;
    end
  end

  // every device with chip select low follows the same stream
  assign sclk_rise = host_mode & ~cs_s & sclk_s & ~sclk_d;  // [RULE17] [RULE20]
  assign sclk_fall = host_mode & ~cs_s & ~sclk_s & sclk_d;  // [RULE20]
  assign word      = {shin[CMD_W-2:0], serial_data_in_s};  // [RULE10]
  assign word_done = sclk_rise && (bitcnt == BITCNT_W'(CMD_W - 1));

  // bit capture, msb first on rising edges
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      shin   <= '0;
      bitcnt <= '0;
    end else if (cs_s || !host_mode) begin
      shin   <= '0;  // [RULE20]
      bitcnt <= '0;  // [RULE20]
    end else if (sclk_rise) begin
      shin   <= word;  // [RULE5] [RULE10]
      bitcnt <= bitcnt + 1'b1;
    end
  end

  // access sequencing: command word then data words
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_CMD;
    end else if (cs_s || !host_mode) begin
      state <= ST_CMD;  // [RULE20]
    end else if (word_done) begin
      case (state)
        ST_CMD: begin
          if (word[CMD_RW_BIT]) begin  // [RULE4]
            state <= ST_RD;
          end else begin
            state <= ST_WR;
          end
        end
        ST_WR: begin
          if (!ainc) begin
            state <= ST_DONE;
          end
        end
        ST_RD: begin
          if (!ainc) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_CMD;
        end
      endcase
    end
  end

  // address and increment mode; a write steps after its strobe, a read before its fetch
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_addr <= '0;
      ainc       <= 1'b0;
      rd_frame   <= 1'b0;
    end else if (word_done && state == ST_CMD) begin
      o_reg_addr <= word[ADDR_W-1:0];  // [RULE4]
      ainc       <= word[CMD_AINC_BIT];  // [RULE4]
      rd_frame   <= word[CMD_RW_BIT];  // [RULE4]
    end else if (ainc && (o_reg_we || (word_done && state == ST_RD))) begin
      o_reg_addr <= o_reg_addr + 1'b1;  // [RULE7]
    end
  end

  // register write strobe at the end of each data word
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_we    <= 1'b0;
      o_reg_wdata <= '0;
    end else begin
      o_reg_we <= word_done && (state == ST_WR);  // [RULE7] [RULE17]
      if (word_done && state == ST_WR) begin
        o_reg_wdata <= word;
      end
    end
  end

  // read fetch: one cycle after the address settles
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fetch_req <= 1'b0;
      o_reg_re  <= 1'b0;
      load_rd   <= 1'b0;
    end else begin
      fetch_req <= word_done && !cs_s
                   && ((state == ST_CMD && word[CMD_RW_BIT])
                       || (state == ST_RD && ainc));  // [RULE7]
      o_reg_re  <= fetch_req;
      load_rd   <= o_reg_re;
    end
  end

  // read shifter: loaded after fetch, advances on falling edges
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_sh <= '0;
    end else if (cs_s || !host_mode) begin
      rd_sh <= '0;
    end else if (load_rd) begin
      rd_sh <= {i_reg_rdata[DATA_W-1:1],
                i_reg_rdata[0] & (ainc | ~i_reg_video)};  // [RULE8]
    end else if (sclk_fall && state == ST_RD && bitcnt != '0) begin
      rd_sh <= {rd_sh[DATA_W-2:0], 1'b0};  // [RULE12] [RULE10]
    end
  end
endmodule

// file: core/shp_host.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module shp_host
  import shp_pkg::*;
(
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic                       i_psel,
  input  wire logic                       i_penable,
  input  wire logic                       i_pwrite,
  input  wire logic [shp_pkg::APB_AW-1:0] i_paddr,
  input  wire logic [31:0]                i_pwdata,
  output logic [31:0]                     o_prdata,
  output logic                            o_pready,
  output logic                            o_pslverr,
  shp_link_if.host                        link
);
  import shp_pkg::*;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_SHIFT = 5'b00010,
    HS_GAP   = 5'b00100,
    HS_END   = 5'b01000,
    HS_HOLD  = 5'b10000
  } shp_host_state_e;

  shp_host_state_e       state;
  logic                  acc;
  logic                  mapped;
  logic                  wr_ev;
  logic                  rd_ev;
  logic                  start;
  logic                  ctrl_rw;
  logic                  ctrl_ainc;
  logic [ADDR_W-1:0]     ctrl_addr;
  logic [CNT_W-1:0]      ctrl_cnt;
  logic [DATA_W-1:0]     txdata;
  logic                  tx_full;
  logic                  tx_take;
  logic [DATA_W-1:0]     rxdata;
  logic                  rx_valid;
  logic                  rx_put;
  logic                  cfg_locked;
  logic                  cfg_jtag;
  logic                  sdo_m;
  logic                  sdo_s;
  logic [CMD_W-1:0]      shreg;
  logic [DATA_W-1:0]     rxsh;
  logic [BITCNT_W-1:0]   bitcnt;
  logic [DIV_W-1:0]      div;
  logic [GAP_W-1:0]      gap;
  logic [CNT_W:0]        words_left;
  logic                  is_cmd;
  logic [GAP_W-1:0]      data_gap;
  logic [GAP_W-1:0]      wr_gap;
  logic                  data_go;
  logic                  half_done;

  assign acc    = i_psel & i_penable;
  assign mapped = (i_paddr == OFS_CTRL) || (i_paddr == OFS_TXDATA) || (i_paddr == OFS_RXDATA)
                  || (i_paddr == OFS_STATUS) || (i_paddr == OFS_CONFIG);
  assign wr_ev  = acc & o_pready & i_pwrite & mapped;
  assign rd_ev  = acc & o_pready & ~i_pwrite & mapped;
  assign start  = wr_ev && (i_paddr == OFS_CTRL) && (state == HS_IDLE);
  assign o_pslverr = acc & o_pready & ~mapped;

  // one wait state: pready and read data registered together
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pready <= 1'b0;
      o_prdata <= '0;
    end else begin
      o_pready <= acc & ~o_pready;
      if (acc && !o_pready && !i_pwrite) begin
        case (i_paddr)
          OFS_CTRL:   o_prdata <= {8'h00, ctrl_cnt, ctrl_rw, 2'h0, ctrl_ainc, ctrl_addr};
          OFS_TXDATA: o_prdata <= {16'h0000, txdata};
          OFS_RXDATA: o_prdata <= {16'h0000, rxdata};
          OFS_STATUS: o_prdata <= {29'h0, rx_valid, tx_full, state != HS_IDLE};
          OFS_CONFIG: o_prdata <= {30'h0, cfg_jtag, cfg_locked};
          default:    o_prdata <= '0;
        endcase
      end
    end
  end

  // software registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_rw    <= 1'b0;
      ctrl_ainc  <= 1'b0;
      ctrl_addr  <= '0;
      ctrl_cnt   <= '0;
      txdata     <= '0;
      cfg_locked <= CONFIG_RST[CFG_LOCK_BIT];
      cfg_jtag   <= CONFIG_RST[CFG_JTAG_BIT];
    end else if (wr_ev) begin
      if (start) begin
        ctrl_rw   <= i_pwdata[CTRL_RW_BIT];
        ctrl_ainc <= i_pwdata[CTRL_AINC_BIT];
        ctrl_addr <= i_pwdata[ADDR_W-1:0];
        // without increment exactly one data word follows
        ctrl_cnt  <= i_pwdata[CTRL_AINC_BIT] ? i_pwdata[CTRL_CNT_LSB +: CNT_W] : '0;  // [RULE6]
      end
      if (i_paddr == OFS_TXDATA) begin
        txdata <= i_pwdata[DATA_W-1:0];
      end
      if (i_paddr == OFS_CONFIG) begin
        cfg_locked <= i_pwdata[CFG_LOCK_BIT];
        cfg_jtag   <= i_pwdata[CFG_JTAG_BIT];
      end
    end
  end

  // flags: a set in the same cycle as a clear wins
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_full  <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      if (tx_take) tx_full <= 1'b0;
      if (wr_ev && i_paddr == OFS_TXDATA) tx_full <= 1'b1;
      if (rd_ev && i_paddr == OFS_RXDATA) rx_valid <= 1'b0;
      if (rx_put) rx_valid <= 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sdo_m <= 1'b0;
      sdo_s <= 1'b0;
    end else begin
      sdo_m <= link.serial_data_out;
      sdo_s <= sdo_m;
    end
  end

  assign wr_gap   = cfg_locked ? WR_GAP_CYC : WR_GAP_UNLK_CYC;  // [RULE14] [RULE19]
  assign data_gap = ctrl_rw ? (cfg_locked ? RD_GAP_CYC : RD_GAP_UNLK_CYC)  // [RULE11] [RULE19]
                            : wr_gap;  // [RULE15]
  assign data_go  = (state == HS_GAP) && (gap == '0) && (words_left != '0)
                    && (ctrl_rw ? !rx_valid : tx_full);
  assign tx_take  = data_go && !ctrl_rw;
  assign half_done = (div == SCLK_HALF_CYC - 1'b1);
  assign rx_put   = (state == HS_SHIFT) && half_done && link.sclk && !is_cmd && ctrl_rw
                    && (bitcnt == BITCNT_W'(DATA_W - 1));
  assign link.serial_data_in        = shreg[CMD_W-1];  // [RULE4] [RULE10]
  assign link.host_select = cfg_jtag;

  // serial engine; clock never faster than the 10 MHz ceiling
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state      <= HS_IDLE;
      link.sclk  <= 1'b0;
      link.cs_n  <= 1'b1;
      shreg      <= '0;
      rxsh       <= '0;
      rxdata     <= '0;
      bitcnt     <= '0;
      div        <= '0;
      gap        <= '0;
      words_left <= '0;
      is_cmd     <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          if (start) begin
            link.cs_n  <= 1'b0;  // [RULE3]
            shreg      <= {i_pwdata[CTRL_RW_BIT], 2'b00, i_pwdata[CTRL_AINC_BIT],
                           i_pwdata[ADDR_W-1:0]};  // [RULE4] [RULE11] [RULE14]
            words_left <= {1'b0, (i_pwdata[CTRL_AINC_BIT] ? i_pwdata[CTRL_CNT_LSB +: CNT_W]
                                                         : CNT_W'(0))} + 1'b1;  // [RULE6]
            is_cmd     <= 1'b1;
            bitcnt     <= '0;
            div        <= '0;
            state      <= HS_SHIFT;
          end
        end
        HS_SHIFT: begin
          div <= half_done ? '0 : div + 1'b1;
          if (half_done) begin
            if (!link.sclk) begin
              link.sclk <= 1'b1;  // [RULE18]
            end else begin
              link.sclk <= 1'b0;
              rxsh      <= {rxsh[DATA_W-2:0], sdo_s};  // [RULE10]
              shreg     <= {shreg[CMD_W-2:0], 1'b0};
              bitcnt    <= bitcnt + 1'b1;
              if (rx_put) begin
                rxdata <= {rxsh[DATA_W-2:0], sdo_s};
              end
              if (bitcnt == BITCNT_W'(CMD_W - 1)) begin
                gap   <= data_gap;
                state <= HS_GAP;
              end
            end
          end
        end
        HS_GAP: begin
          if (gap != '0) begin
            gap <= gap - 1'b1;  // [RULE11] [RULE14] [RULE15]
          end else if (words_left == '0) begin
            gap   <= wr_gap;
            state <= HS_END;
          end else if (data_go) begin
            shreg      <= ctrl_rw ? '0 : txdata;
            words_left <= words_left - 1'b1;
            is_cmd     <= 1'b0;
            bitcnt     <= '0;
            div        <= '0;
            state      <= HS_SHIFT;
          end
        end
        HS_END: begin
          if (gap != '0) begin
            gap <= gap - 1'b1;
          end else begin
            link.cs_n <= 1'b1;  // [RULE3] [RULE13]
            gap       <= wr_gap;
            state     <= HS_HOLD;
          end
        end
        HS_HOLD: begin
          if (gap != '0) begin
            gap <= gap - 1'b1;  // [RULE14]
          end else begin
            state <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end
endmodule

// file: core/shp_link_if.sv
`timescale 1ns/100ps
interface shp_link_if;
  logic sclk;
  logic cs_n;
  logic serial_data_in;
  logic serial_data_out;
  logic host_select;

  modport dev (
    input  sclk,
    input  cs_n,
    input  serial_data_in,
    input  host_select,
    output serial_data_out
  );

  modport host (
    output sclk,
    output cs_n,
    output serial_data_in,
    output host_select,
    input  serial_data_out
  );
endinterface

// file: core/shp_pkg.sv
package shp_pkg;
  // serial word layout
  localparam int CMD_W        = 16;
  localparam int ADDR_W       = 12;
  localparam int DATA_W       = 16;
  localparam int BITCNT_W     = 4;
  localparam int CMD_RW_BIT   = 15;
  localparam int CMD_AINC_BIT = 12;

  // system clock and link timing
  localparam int CLK_MHZ          = 100;
  localparam int T_WR_GAP_NS      = 37;
  localparam int T_RD_GAP_NS      = 148;
  localparam int T_WR_GAP_UNLK_NS = 445;
  localparam int T_RD_GAP_UNLK_NS = 1187;
  localparam int T_SCLK_PER_NS    = 100;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int GAP_W = 11;
  localparam logic [GAP_W-1:0] WR_GAP_CYC      = GAP_W'(ns_to_cyc(T_WR_GAP_NS));
  localparam logic [GAP_W-1:0] RD_GAP_CYC      = GAP_W'(ns_to_cyc(T_RD_GAP_NS));
  localparam logic [GAP_W-1:0] WR_GAP_UNLK_CYC = GAP_W'(ns_to_cyc(T_WR_GAP_UNLK_NS));
  localparam logic [GAP_W-1:0] RD_GAP_UNLK_CYC = GAP_W'(ns_to_cyc(T_RD_GAP_UNLK_NS));
  localparam int DIV_W = 4;
  localparam logic [DIV_W-1:0] SCLK_HALF_CYC  = DIV_W'(ns_to_cyc(T_SCLK_PER_NS / 2));

  // host controller registers on apb
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [APB_AW-1:0] OFS_TXDATA = 8'h04;
  localparam logic [APB_AW-1:0] OFS_RXDATA = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h0C;
  localparam logic [APB_AW-1:0] OFS_CONFIG = 8'h10;
  localparam int CTRL_AINC_BIT = 12;
  localparam int CTRL_RW_BIT   = 15;
  localparam int CTRL_CNT_LSB  = 16;
  localparam int CNT_W         = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_TXF_BIT  = 1;
  localparam int STAT_RXV_BIT  = 2;
  localparam int CFG_LOCK_BIT  = 0;
  localparam int CFG_JTAG_BIT  = 1;
  localparam logic [1:0] CONFIG_RST = 2'h0;
endpackage

// file: tb/shp_chk.sv
`timescale 1ns/100ps
module shp_chk
  import shp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic host_select
);
  import shp_pkg::*;

  logic       sclk_q;
  logic       rd_cmd;
  logic       rd_data;
  logic       rise;
  logic [7:0] rise_cnt;
  logic [7:0] low_cnt;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  assign rise = sclk && !sclk_q;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q  <= 1'h0;
      low_cnt <= 8'h00;
    end else begin
      sclk_q  <= sclk;
      low_cnt <= sclk ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
    end
  end

  // rises per frame; read data phase starts after the sixteenth rise
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_cnt <= 8'h00;
      rd_cmd   <= 1'h0;
      rd_data  <= 1'h0;
    end else if (cs_n) begin
      rise_cnt <= 8'h00;
    end else if (rise) begin
      rise_cnt <= rise_cnt + 8'h01;
      if (rise_cnt == 8'h00) begin
        rd_cmd  <= serial_data_in;
        rd_data <= 1'h0;
      end
      if (rise_cnt == 8'h0F) begin
        rd_data <= rd_cmd;
      end
    end
  end

  sclk_idle_a: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside a frame");
  half_per_a: assert property ($rose(sclk) |-> sclk [*5] ##1 !sclk)
    else $error("link clock high phase not five cycles");
  cs_setup_a: assert property (rise |-> !cs_n && $past(!cs_n))
    else $error("link clock rose without chip select set up");
  serial_data_in_hold_a: assert property (sclk && sclk_q |-> $stable(serial_data_in))
    else $error("serial input changed while clock high");
  word_gap_a: assert property (rise && rise_cnt != 8'h00 && rise_cnt[3:0] == 4'h0
    |-> GAP_W'(low_cnt) >= (rd_cmd ? RD_GAP_CYC : WR_GAP_CYC))
    else $error("wait before data word too short");
  whole_word_a: assert property ($rose(cs_n) |-> rise_cnt[3:0] == 4'h0 && rise_cnt >= 8'h20)
    else $error("frame ended without whole command and data");
  cs_hold_a: assert property ($rose(cs_n) |-> low_cnt >= 8'h04)
    else $error("chip select released too soon");
  loop_a: assert property (!host_select && !rd_data |-> serial_data_out == serial_data_in)
    else $error("serial output is not a copy of serial input");
  rd_hold_a: assert property (rd_data && rise |-> $stable(serial_data_out) ##1 $stable(serial_data_out) [*3])
    else $error("read bit changed near a rising clock");

  rd_frame_c: cover property (rd_data && rise);
  ainc_c: cover property (rise && rise_cnt == 8'h30);
  test_port_c: cover property (host_select);
  unlk_gap_c: cover property (rise && rd_cmd && low_cnt > 8'h76);
endmodule

// file: tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import shp_pkg::*;

  typedef struct packed {
    logic        rw;
    logic        ainc;
    logic        lock;
    logic        poke;
    logic [11:0] addr;
    logic [7:0]  extra;
  } shp_row_s;

  localparam int TMO = 60000;
  logic        i_clk = 1'h0;
  logic        i_rst_b = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [15:0] reg_rdata = 16'h0000;
  logic        reg_video = 1'h0;
  logic        tck;
  logic        tms;
  logic        tdi;
  logic        tdo = 1'h0;
  logic        sclk_q = 1'h0;
  logic [31:0] lowc = 32'h0;
  logic [31:0] gap17 = 32'h0;
  int          rises = 0;
  int          cyc = 0;
  int          error_cnt = 0;
  int          tests_run = 0;
  logic [15:0] mem [0:4095];
  logic [27:0] wlog [$];
  shp_row_s    rows [8] = '{
    '{1'h0, 1'h0, 1'h1, 1'h0, 12'h005, 8'h00},
    '{1'h0, 1'h1, 1'h1, 1'h0, 12'h0FE, 8'h02},
    '{1'h0, 1'h0, 1'h1, 1'h0, 12'hFFF, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 12'h123, 8'h00},
    '{1'h1, 1'h0, 1'h1, 1'h0, 12'h010, 8'h00},
    '{1'h1, 1'h1, 1'h1, 1'h0, 12'h020, 8'h01},
    '{1'h1, 1'h1, 1'h0, 1'h0, 12'h0FE, 8'h01},
    '{1'h0, 1'h0, 1'h0, 1'h1, 12'h300, 8'h00}
  };

  always #5 i_clk = ~i_clk;

  shp_link_if link ();
  shp_host u_shp_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .link(link));
  shp_dev u_shp_dev (.i_clk(i_clk), .i_rst_b(i_rst_b), .link(link), .o_reg_addr(reg_addr),
    .o_reg_wdata(reg_wdata), .o_reg_we(reg_we), .o_reg_re(reg_re), .i_reg_rdata(reg_rdata),
    .i_reg_video(reg_video), .o_jtag_tck(tck), .o_jtag_tms(tms), .o_jtag_tdi(tdi),
    .i_jtag_tdo(tdo));
  shp_chk u_shp_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .sclk(link.sclk), .cs_n(link.cs_n),
    .serial_data_in(link.serial_data_in), .serial_data_out(link.serial_data_out), .host_select(link.host_select));

  // register file behind the device; addresses below 0x100 count as video registers
  always @(posedge i_clk) begin
    reg_rdata <= mem[reg_addr];
    reg_video <= reg_addr < 12'h100;
    if (reg_we === 1'h1) begin
      mem[reg_addr] <= reg_wdata;
      wlog.push_back({reg_addr, reg_wdata});
    end
  end

  // low time of the link clock before the first data rise, and the run limit
  always @(posedge i_clk) begin
    sclk_q <= link.sclk;
    lowc <= link.sclk ? 32'h0 : lowc + 32'h1;
    cyc <= cyc + 1;
    if (link.cs_n !== 1'h0) begin
      rises <= 0;
    end else if (link.sclk && !sclk_q) begin
      rises <= rises + 1;
      if (rises == 16) begin
        gap17 <= lowc;
      end
    end
    if (cyc == TMO) begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge i_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    penable <= 1'h1;
    do @(posedge i_clk); while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, wd, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r, output logic e);
    apb(1'h0, a, 32'h0, r, e);
  endtask

  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    logic        e;
    do rd(OFS_STATUS, r, e); while (r[b] !== v);
  endtask

  task automatic xfer(input shp_row_s w, input logic [15:0] seed);
    logic [31:0] d;
    logic        e;
    logic [15:0] exp;
    logic [11:0] a;
    logic [10:0] gmin;
    int          n;
    n = w.ainc ? int'(w.extra) + 1 : 1;
    wlog.delete();
    wr(OFS_CONFIG, {31'h0, w.lock});
    wr(OFS_CTRL, {8'h00, w.extra, w.rw, 2'h0, w.ainc, w.addr});
    if (w.poke) begin
      wr(OFS_CTRL, 32'h0000_0777);
    end
    for (int k = 0; k < n; k++) begin
      a = w.addr + 12'(k);
      if (w.rw) begin
        poll(STAT_RXV_BIT, 1'h1);
        rd(OFS_RXDATA, d, e);
        exp = mem[a];
        if (!w.ainc && a < 12'h100) begin
          exp[0] = 1'h0;
        end
        check(d, {16'h0000, exp});
      end else begin
        wr(OFS_TXDATA, {16'h0000, seed + 16'(k)});
        poll(STAT_TXF_BIT, 1'h0);
      end
    end
    poll(STAT_BUSY_BIT, 1'h0);
    if (!w.rw) begin
      check(32'(wlog.size()), 32'(n));
      for (int k = 0; k < n && k < wlog.size(); k++) begin
        check({4'h0, wlog[k]}, {4'h0, w.addr + 12'(k), seed + 16'(k)});
      end
    end
    gmin = w.rw ? (w.lock ? RD_GAP_CYC : RD_GAP_UNLK_CYC) : (w.lock ? WR_GAP_CYC : WR_GAP_UNLK_CYC);
    check({31'h0, gap17 >= 32'(gmin)}, 32'h1);
  endtask

  initial begin
    logic [31:0] d;
    logic        e;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = {i[11:0], 4'h5};
    end
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'h1;
    @(posedge i_clk);
    check({28'h0, link.cs_n, link.sclk, link.serial_data_in, link.host_select}, 32'h8);
    rd(OFS_STATUS, d, e);
    check(d, 32'h0);
    rd(OFS_CONFIG, d, e);
    check(d, {30'h0, CONFIG_RST});
    for (int i = 0; i < 8; i++) begin
      xfer(rows[i], 16'h5A30 + 16'(i));
    end
    // unmapped offset
    rd(8'h14, d, e);
    check({31'h0, e}, 32'h1);
    // test port owns the shared pins
    wr(OFS_CONFIG, 32'h2);
    for (int v = 0; v < 2; v++) begin
      tdo <= v[0];
      repeat (2) @(posedge i_clk);
      check({28'h0, link.serial_data_out, tck, tms, tdi}, {28'h0, v[0], link.sclk, link.cs_n, link.serial_data_in});
    end
    wr(OFS_CONFIG, 32'h1);
    @(posedge i_clk);
    check({29'h0, tck, tms, tdi}, 32'h2);
    // reset in mid-frame; the next access must start from a fresh command
    wr(OFS_CTRL, 32'h0000_0456);
    while (rises < 8) begin
      @(posedge i_clk);
    end
    i_rst_b <= 1'h0;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'h1;
    check({31'h0, link.cs_n}, 32'h1);
    xfer('{1'h0, 1'h0, 1'h1, 1'h0, 12'h456, 8'h00}, 16'h0F0F);
    report_and_stop();
  end
endmodule
